/* hdl/scd_pwm.sv */
`timescale 1ns/10ps
`include "scd_defines.svh"

// Sawtooth counter PWM; duty 255 gives 100 % on-time
module scd_pwm (
  input wire logic aclk,
  input wire logic aresetn,
  input wire logic [7:0] duty,
  output logic pwm_on,
  output logic cycle_start
);
  import scd_pkg::*;

  scd_pwm_state_t r;
  scd_pwm_state_t n;
  logic tick;

  always_comb begin
    n = r;
    tick = (r.div == `SCD_PWM_DIV_LAST);
    n.div = tick ? 8'h00 : 8'(r.div + 8'h01);
    n.start = 1'b0;
    if (tick) begin
      if (r.cnt == `SCD_PWM_TOP) begin
        n.cnt = 8'h00;
        n.start = 1'b1;
      end else begin
        n.cnt = 8'(r.cnt + 8'h01);
      end
    end
    n.on = (n.cnt < duty);
  end

  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      r <= '0;
    end else begin
      r <= n;
    end
  end

  assign pwm_on = r.on;
  assign cycle_start = r.start;
endmodule

/* hdl/scd_sync.sv */
`timescale 1ns/10ps
`include "scd_defines.svh"

// Two-flop synchroniser for a bundle of asynchronous pins
module scd_sync #(
  parameter int W = `SCD_PIN_W
) (
  input wire logic aclk,
  input wire logic aresetn,
  input wire logic [W-1:0] async_in,
  output logic [W-1:0] sync_out
);
  typedef struct packed {
    logic [W-1:0] stage1;
    logic [W-1:0] stage2;
  } scd_sync_state_t;

  scd_sync_state_t r;
  scd_sync_state_t n;

  always_comb begin
    n = r;
    n.stage1 = async_in;
    n.stage2 = r.stage1;
  end

  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      r <= '0;
    end else begin
      r <= n;
    end
  end

  assign sync_out = r.stage2;
endmodule

/* hdl/scd_top.sv */
`timescale 1ns/10ps
`include "scd_defines.svh"

module scd_top (
  input wire logic aclk,
  input wire logic aresetn,
  input wire logic [31:0] s_axi_awaddr,
  input wire logic s_axi_awvalid,
  output logic s_axi_awready,
  input wire logic [31:0] s_axi_wdata,
  input wire logic [3:0] s_axi_wstrb,
  input wire logic s_axi_wvalid,
  output logic s_axi_wready,
  output logic [1:0] s_axi_bresp,
  output logic s_axi_bvalid,
  input wire logic s_axi_bready,
  input wire logic [31:0] s_axi_araddr,
  input wire logic s_axi_arvalid,
  output logic s_axi_arready,
  output logic [31:0] s_axi_rdata,
  output logic [1:0] s_axi_rresp,
  output logic s_axi_rvalid,
  input wire logic s_axi_rready,
  input wire logic hall_input_a,
  input wire logic hall_input_b,
  input wire logic hall_input_c,
  input wire logic phase_sel_open,
  input wire logic direction_fwd,
  input wire logic brake,
  input wire logic output_enable,
  input wire logic overcurrent,
  input wire logic undervoltage,
  input wire logic over_temp,
  output logic upper_drive_a,
  output logic upper_drive_b,
  output logic upper_drive_c,
  output logic lower_drive_a,
  output logic lower_drive_b,
  output logic lower_drive_c,
  output logic fault_n,
  output logic irq
);
  import scd_pkg::*;

  scd_state_t r;
  scd_state_t n;
  logic [`SCD_PIN_W-1:0] pins_async;
  logic [`SCD_PIN_W-1:0] pins;
  logic pwm_on;
  logic pwm_start;

  // Hall code is {a,b,c}, bit 0 of a drive vector is phase a
  logic [2:0] hall;
  logic ph_open;
  logic dir_fwd;
  logic brk;
  logic en_eff;
  logic oc;
  logic uv;
  logic ot;
  logic dec_valid;
  logic [2:0] dec_step;
  logic [2:0] pat_upper;
  logic [2:0] pat_lower;
  logic [`SCD_IRQ_W-1:0] events;
  logic [`SCD_IRQ_W-1:0] clr;
  logic [31:0] status_word;
  logic [31:0] waddr;
  logic [31:0] raddr;

  assign pins_async[`SCD_PIN_HALL_A] = hall_input_a;
  assign pins_async[`SCD_PIN_HALL_B] = hall_input_b;
  assign pins_async[`SCD_PIN_HALL_C] = hall_input_c;
  assign pins_async[`SCD_PIN_PH_OPEN] = phase_sel_open;
  assign pins_async[`SCD_PIN_DIR] = direction_fwd;
  assign pins_async[`SCD_PIN_BRAKE] = brake;
  assign pins_async[`SCD_PIN_ENABLE] = output_enable;
  assign pins_async[`SCD_PIN_OVERCUR] = overcurrent;
  assign pins_async[`SCD_PIN_UNDERV] = undervoltage;
  assign pins_async[`SCD_PIN_THERMAL] = over_temp;

  scd_sync #(
    .W(`SCD_PIN_W)
  ) u_sync (
    .aclk(aclk),
    .aresetn(aresetn),
    .async_in(pins_async),
    .sync_out(pins)
  );

  scd_pwm u_pwm (
    .aclk(aclk),
    .aresetn(aresetn),
    .duty(r.duty),
    .pwm_on(pwm_on),
    .cycle_start(pwm_start)
  );

  // Returns {valid, step}; both tables share steps 0, 1, 3 and 4
  function automatic logic [3:0] decode(input logic [2:0] code,
                                        input logic open60);
    logic [3:0] res;
    res = 4'h0;
    case (code)
      3'h4: res = 4'h8;
      3'h6: res = 4'h9;
      3'h7: res = open60 ? 4'ha : 4'h0;
      3'h2: res = open60 ? 4'h0 : 4'ha;
      3'h3: res = 4'hb;
      3'h1: res = 4'hc;
      3'h0: res = open60 ? 4'hd : 4'h0;
      3'h5: res = open60 ? 4'h0 : 4'hd;
      default: res = 4'h0;
    endcase
    return res;
  endfunction

  // Returns {upper, lower} one-hot pair for a forward step
  function automatic logic [5:0] pattern(input logic [2:0] step);
    logic [5:0] res;
    res = 6'h00;
    case (step)
      3'h0: res = {3'h2, 3'h4};
      3'h1: res = {3'h2, 3'h1};
      3'h2: res = {3'h4, 3'h1};
      3'h3: res = {3'h4, 3'h2};
      3'h4: res = {3'h1, 3'h2};
      3'h5: res = {3'h1, 3'h4};
      default: res = 6'h00;
    endcase
    return res;
  endfunction

  always_comb begin
    hall = {pins[`SCD_PIN_HALL_A], pins[`SCD_PIN_HALL_B],
            pins[`SCD_PIN_HALL_C]};
    ph_open = pins[`SCD_PIN_PH_OPEN];
    dir_fwd = pins[`SCD_PIN_DIR];
    brk = pins[`SCD_PIN_BRAKE];
    oc = pins[`SCD_PIN_OVERCUR];
    uv = pins[`SCD_PIN_UNDERV];
    ot = pins[`SCD_PIN_THERMAL];
    en_eff = pins[`SCD_PIN_ENABLE] & ~ot;
    {dec_valid, dec_step} = decode(hall, ph_open);
    {pat_upper, pat_lower} = pattern(dec_step);
    if (!dir_fwd) begin
      // Swapping upper and lower reverses the torque of every step
      {pat_upper, pat_lower} = {pat_lower, pat_upper};
    end
  end

  always_comb begin
    status_word = 32'h0000_0000;
    status_word[`SCD_ST_HALL_MSB:`SCD_ST_HALL_LSB] = r.hall_prev;
    status_word[`SCD_ST_VALID] = r.code_valid;
    status_word[`SCD_ST_STEP_MSB:`SCD_ST_STEP_LSB] = r.step;
    status_word[`SCD_ST_FAULT_N] = r.fault_n;
    status_word[`SCD_ST_OC_LATCH] = r.oc_latch;
    status_word[`SCD_ST_DIR] = dir_fwd;
    status_word[`SCD_ST_PH_OPEN] = ph_open;
    status_word[`SCD_ST_BRAKE] = brk;
    status_word[`SCD_ST_ENABLE] = en_eff;
  end

  always_comb begin
    n = r;
    waddr = {r.awaddr[31:2], 2'h0};
    raddr = {s_axi_araddr[31:2], 2'h0};
    clr = '0;

    // Motor side
    n.hall_prev = hall;
    n.code_valid = dec_valid;
    if (dec_valid) begin
      n.step = dec_step;
    end
    // Outside brake, overcurrent ends the lower conduction until the next PWM period
    if (oc) begin
      n.oc_latch = 1'b1;
    end else if (pwm_start) begin
      n.oc_latch = 1'b0;
    end
    n.upper = 3'h0;
    n.lower = 3'h0;
    if (uv) begin
      // Undervoltage holds every drive off, brake included
      n.upper = 3'h0;
    end else if (brk) begin
      n.lower = 3'h7;
    end else if (en_eff && dec_valid) begin
      n.upper = pat_upper;
      n.lower = (pwm_on && !n.oc_latch) ? pat_lower : 3'h0;
    end
    n.fault_n = !(!dec_valid || !en_eff || oc || uv || ot);

    events = '0;
    events[`SCD_IRQ_STEP] = dec_valid && r.code_valid &&
                            (hall != r.hall_prev);
    events[`SCD_IRQ_INVALID] = !dec_valid;
    events[`SCD_IRQ_OVERCUR] = oc;
    events[`SCD_IRQ_UNDERV] = uv;
    events[`SCD_IRQ_THERMAL] = ot;
    // Pins read as zero until the synchroniser has filled: no false events
    n.sync_fill = {r.sync_fill[0], 1'b1};
    if (!r.sync_fill[1]) begin
      events = '0;
    end

    // AXI4-Lite write
    if (s_axi_awvalid && s_axi_awready) begin
      n.aw_have = 1'b1;
      n.awaddr = s_axi_awaddr;
    end
    if (s_axi_wvalid && s_axi_wready) begin
      n.w_have = 1'b1;
      n.wdata = s_axi_wdata;
      n.wstrb = s_axi_wstrb;
    end
    if (r.aw_have && r.w_have && !r.bvalid) begin
      n.aw_have = 1'b0;
      n.w_have = 1'b0;
      n.bvalid = 1'b1;
      n.bresp = `SCD_RESP_OKAY;
      case (waddr)
        `SCD_ADDR_CTRL: begin
          if (r.wstrb[0]) begin
            n.duty = r.wdata[7:0];
          end
        end
        `SCD_ADDR_STATUS: n.bresp = `SCD_RESP_OKAY;
        `SCD_ADDR_IRQ_STATUS: begin
          if (r.wstrb[0]) begin
            clr = r.wdata[`SCD_IRQ_W-1:0];
          end
        end
        `SCD_ADDR_IRQ_MASK: begin
          if (r.wstrb[0]) begin
            n.irq_mask = r.wdata[`SCD_IRQ_W-1:0];
          end
        end
        default: n.bresp = `SCD_RESP_DECERR;
      endcase
    end
    if (r.bvalid && s_axi_bready) begin
      n.bvalid = 1'b0;
    end

    // A new event in the clearing cycle keeps its bit set
    n.irq_stat = (r.irq_stat & ~clr) | events;
    n.irq = |(n.irq_stat & n.irq_mask);

    // AXI4-Lite read
    if (s_axi_arvalid && s_axi_arready) begin
      n.rvalid = 1'b1;
      n.rresp = `SCD_RESP_OKAY;
      case (raddr)
        `SCD_ADDR_CTRL: n.rdata = {24'h00_0000, r.duty};
        `SCD_ADDR_STATUS: n.rdata = status_word;
        `SCD_ADDR_IRQ_STATUS: n.rdata = {27'h000_0000, r.irq_stat};
        `SCD_ADDR_IRQ_MASK: n.rdata = {27'h000_0000, r.irq_mask};
        default: begin
          n.rdata = 32'h0000_0000;
          n.rresp = `SCD_RESP_DECERR;
        end
      endcase
    end else if (r.rvalid && s_axi_rready) begin
      n.rvalid = 1'b0;
    end
  end

  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      r <= '0;
      r.duty <= `SCD_DUTY_RST;
      r.irq_mask <= `SCD_MASK_RST;
    end else begin
      r <= n;
    end
  end

  assign s_axi_awready = !r.aw_have && !r.bvalid;
  assign s_axi_wready = !r.w_have && !r.bvalid;
  assign s_axi_bvalid = r.bvalid;
  assign s_axi_bresp = r.bresp;
  assign s_axi_arready = !r.rvalid;
  assign s_axi_rvalid = r.rvalid;
  assign s_axi_rdata = r.rdata;
  assign s_axi_rresp = r.rresp;
  assign upper_drive_a = r.upper[0];
  assign upper_drive_b = r.upper[1];
  assign upper_drive_c = r.upper[2];
  assign lower_drive_a = r.lower[0];
  assign lower_drive_b = r.lower[1];
  assign lower_drive_c = r.lower[2];
  assign fault_n = r.fault_n;
  assign irq = r.irq;
endmodule

/* pkg/scd_defines.svh */
`ifndef SCD_DEFINES_SVH
`define SCD_DEFINES_SVH

// Register byte addresses (word aligned)
`define SCD_ADDR_CTRL 32'h0000_0000
`define SCD_ADDR_STATUS 32'h0000_0004
`define SCD_ADDR_IRQ_STATUS 32'h0000_0008
`define SCD_ADDR_IRQ_MASK 32'h0000_000c

// AXI responses
`define SCD_RESP_OKAY 2'h0
`define SCD_RESP_DECERR 2'h3

// Reset values
`define SCD_DUTY_RST 8'hff
`define SCD_MASK_RST 5'h00

// Interrupt bit positions
`define SCD_IRQ_STEP 0
`define SCD_IRQ_INVALID 1
`define SCD_IRQ_OVERCUR 2
`define SCD_IRQ_UNDERV 3
`define SCD_IRQ_THERMAL 4
`define SCD_IRQ_W 5

// Status register field positions
`define SCD_ST_HALL_LSB 0
`define SCD_ST_HALL_MSB 2
`define SCD_ST_VALID 3
`define SCD_ST_STEP_LSB 4
`define SCD_ST_STEP_MSB 6
`define SCD_ST_FAULT_N 7
`define SCD_ST_OC_LATCH 8
`define SCD_ST_DIR 9
`define SCD_ST_PH_OPEN 10
`define SCD_ST_BRAKE 11
`define SCD_ST_ENABLE 12

// Synchronised pin vector positions
`define SCD_PIN_HALL_C 0
`define SCD_PIN_HALL_B 1
`define SCD_PIN_HALL_A 2
`define SCD_PIN_PH_OPEN 3
`define SCD_PIN_DIR 4
`define SCD_PIN_BRAKE 5
`define SCD_PIN_ENABLE 6
`define SCD_PIN_OVERCUR 7
`define SCD_PIN_UNDERV 8
`define SCD_PIN_THERMAL 9
`define SCD_PIN_W 10

// PWM timing: one count every 4 clocks, 255 counts a period (~98 kHz)
`define SCD_PWM_DIV_LAST 8'h03
`define SCD_PWM_TOP 8'hfe

`endif

/* pkg/scd_pkg.sv */
`include "scd_defines.svh"

package scd_pkg;

  typedef struct packed {
    logic aw_have;
    logic [31:0] awaddr;
    logic w_have;
    logic [31:0] wdata;
    logic [3:0] wstrb;
    logic bvalid;
    logic [1:0] bresp;
    logic rvalid;
    logic [31:0] rdata;
    logic [1:0] rresp;
    logic [7:0] duty;
    logic [`SCD_IRQ_W-1:0] irq_stat;
    logic [`SCD_IRQ_W-1:0] irq_mask;
    logic [2:0] hall_prev;
    logic [2:0] step;
    logic code_valid;
    logic oc_latch;
    logic [2:0] upper;
    logic [2:0] lower;
    logic fault_n;
    logic irq;
    logic [1:0] sync_fill;
  } scd_state_t;

  typedef struct packed {
    logic [7:0] div;
    logic [7:0] cnt;
    logic on;
    logic start;
  } scd_pwm_state_t;

endpackage

/* tb/scd_hall_model.sv */
`timescale 1ns/10ps

module scd_hall_model (
  input wire logic [2:0] pos,
  input wire logic phase_sel_open,
  output logic hall_input_a,
  output logic hall_input_b,
  output logic hall_input_c
);
  // Slots 6 and 7 hold the two codes this phasing never produces
  logic [2:0] t_open [8];
  logic [2:0] t_gnd [8];
  assign t_open = '{3'h4, 3'h6, 3'h7, 3'h3, 3'h1, 3'h0, 3'h2, 3'h5};
  assign t_gnd = '{3'h4, 3'h6, 3'h2, 3'h3, 3'h1, 3'h5, 3'h7, 3'h0};
  assign {hall_input_a, hall_input_b, hall_input_c} =
    phase_sel_open ? t_open[pos] : t_gnd[pos];
endmodule

/* tb/scd_monitor.sv */
`timescale 1ns/10ps

module scd_monitor (
  input wire logic aclk,
  input wire logic aresetn,
  input wire logic s_axi_awready,
  input wire logic s_axi_wready,
  input wire logic s_axi_bvalid,
  input wire logic s_axi_arvalid,
  input wire logic s_axi_arready,
  input wire logic s_axi_rvalid,
  input wire logic hall_input_a,
  input wire logic hall_input_b,
  input wire logic hall_input_c,
  input wire logic phase_sel_open,
  input wire logic direction_fwd,
  input wire logic brake,
  input wire logic output_enable,
  input wire logic overcurrent,
  input wire logic undervoltage,
  input wire logic over_temp,
  input wire logic upper_drive_a,
  input wire logic upper_drive_b,
  input wire logic upper_drive_c,
  input wire logic lower_drive_a,
  input wire logic lower_drive_b,
  input wire logic lower_drive_c,
  input wire logic fault_n
);
  logic [2:0] up;
  logic [2:0] lo;
  logic [8:0] pins;
  assign up = {upper_drive_a, upper_drive_b, upper_drive_c};
  assign lo = {lower_drive_a, lower_drive_b, lower_drive_c};
  assign pins = {hall_input_a, hall_input_b, hall_input_c, phase_sel_open,
    direction_fwd, brake, output_enable, over_temp, undervoltage};
  default clocking @(posedge aclk); endclocking
  default disable iff (!aresetn);
  // Six cycles covers the synchroniser plus the output register
  sequence s_held(x);
    x[*6];
  endsequence
  sequence s_quiet;
    $stable(pins)[*8];
  endsequence
  AST_PAIR: assert property (|up |-> $onehot(up) &&
    $countones(lo) <= 1 && (up & lo) == 3'h0) else $error("bad pair");
  AST_BRAKE: assert property (s_held(brake && !undervoltage) |->
    up == 3'h0 && lo == 3'h7) else $error("brake pattern");
  AST_ENABLE: assert property (s_held(!output_enable) |->
    !fault_n && up == 3'h0) else $error("enable low drives");
  AST_THERMAL: assert property (s_held(over_temp) |->
    !fault_n && up == 3'h0) else $error("thermal drives");
  AST_UNDERV: assert property (s_held(undervoltage) |->
    !fault_n && up == 3'h0 && lo == 3'h0) else $error("uv drives");
  AST_OVERCUR: assert property (s_held(overcurrent) |->
    !fault_n) else $error("overcurrent fault");
  AST_UPPER_STEADY: assert property (s_quiet |-> $stable(up))
    else $error("upper moved");
  AST_RD_ANSWER: assert property ($rose(s_axi_rvalid) |->
    $past(s_axi_arvalid) && $past(s_axi_arready)) else $error("rd early");
  AST_REFUSE: assert property (s_axi_bvalid |-> !s_axi_awready &&
    !s_axi_wready) else $error("accepted with response pending");
endmodule

/* tb/test_six_step_commutation_decoder.sv */
`timescale 1ns/10ps
`include "scd_defines.svh"

module test_six_step_commutation_decoder;
  logic aclk, aresetn, s_axi_awvalid, s_axi_wvalid, s_axi_bready;
  logic s_axi_arvalid, s_axi_rready, phase_sel_open, direction_fwd;
  logic brake, output_enable, overcurrent, undervoltage, over_temp;
  logic [31:0] s_axi_awaddr, s_axi_wdata, s_axi_araddr, s_axi_rdata;
  logic [3:0] s_axi_wstrb;
  logic [1:0] s_axi_bresp, s_axi_rresp;
  logic s_axi_awready, s_axi_wready, s_axi_bvalid, s_axi_arready;
  logic s_axi_rvalid, upper_drive_a, upper_drive_b, upper_drive_c;
  logic lower_drive_a, lower_drive_b, lower_drive_c, fault_n, irq;
  logic hall_input_a, hall_input_b, hall_input_c;
  logic [2:0] pos, up, lo;
  logic [5:0] rows [6];
  logic [5:0] e;
  int err_count, cmp_count, ons;
  assign up = {upper_drive_a, upper_drive_b, upper_drive_c};
  assign lo = {lower_drive_a, lower_drive_b, lower_drive_c};
  // Forward {upper, lower} for steps 0 to 5
  assign rows = '{6'h11, 6'h14, 6'h0c, 6'h0a, 6'h22, 6'h21};

  scd_top i_dut (
    .aclk(aclk),
    .aresetn(aresetn),
    .s_axi_awaddr(s_axi_awaddr),
    .s_axi_awvalid(s_axi_awvalid),
    .s_axi_awready(s_axi_awready),
    .s_axi_wdata(s_axi_wdata),
    .s_axi_wstrb(s_axi_wstrb),
    .s_axi_wvalid(s_axi_wvalid),
    .s_axi_wready(s_axi_wready),
    .s_axi_bresp(s_axi_bresp),
    .s_axi_bvalid(s_axi_bvalid),
    .s_axi_bready(s_axi_bready),
    .s_axi_araddr(s_axi_araddr),
    .s_axi_arvalid(s_axi_arvalid),
    .s_axi_arready(s_axi_arready),
    .s_axi_rdata(s_axi_rdata),
    .s_axi_rresp(s_axi_rresp),
    .s_axi_rvalid(s_axi_rvalid),
    .s_axi_rready(s_axi_rready),
    .hall_input_a(hall_input_a),
    .hall_input_b(hall_input_b),
    .hall_input_c(hall_input_c),
    .phase_sel_open(phase_sel_open),
    .direction_fwd(direction_fwd),
    .brake(brake),
    .output_enable(output_enable),
    .overcurrent(overcurrent),
    .undervoltage(undervoltage),
    .over_temp(over_temp),
    .upper_drive_a(upper_drive_a),
    .upper_drive_b(upper_drive_b),
    .upper_drive_c(upper_drive_c),
    .lower_drive_a(lower_drive_a),
    .lower_drive_b(lower_drive_b),
    .lower_drive_c(lower_drive_c),
    .fault_n(fault_n),
    .irq(irq)
  );
  scd_hall_model i_hall (
    .pos(pos),
    .phase_sel_open(phase_sel_open),
    .hall_input_a(hall_input_a),
    .hall_input_b(hall_input_b),
    .hall_input_c(hall_input_c)
  );

  task automatic final_report();
    $display("compares %0d mismatches %0d", cmp_count, err_count);
    if (err_count == 0 && cmp_count > 0) begin
      $display("SIMULATION PASSED");
    end else begin
      $display("SIMULATION FAILED");
    end
    $finish;
  endtask

  task automatic chk(input logic [31:0] got, input logic [31:0] exp);
    cmp_count++;
    if (got !== exp) begin
      err_count++;
      $display("[FAIL] %0t got %h exp %h", $time, got, exp);
    end
  endtask

  task automatic hang(input int n);
    if (n > 200) begin
      err_count++;
      final_report();
    end
  endtask

  // Readies are sampled mid-cycle so the edge race cannot matter
  task automatic wr(input logic [31:0] a, input logic [31:0] d,
                    input logic [1:0] x);
    int n;
    logic aw, w, b;
    n = 0;
    @(posedge aclk);
    s_axi_awaddr <= a;
    s_axi_wdata <= d;
    s_axi_awvalid <= 1'b1;
    s_axi_wvalid <= 1'b1;
    s_axi_bready <= 1'b1;
    do begin
      @(negedge aclk);
      aw = s_axi_awready;
      w = s_axi_wready;
      b = s_axi_bvalid;
      if (b) begin
        chk(32'(s_axi_bresp), 32'(x));
      end
      @(posedge aclk);
      if (aw) s_axi_awvalid <= 1'b0;
      if (w) s_axi_wvalid <= 1'b0;
      n++;
      hang(n);
    end while (!b);
    s_axi_bready <= 1'b0;
  endtask

  task automatic rd(input logic [31:0] a, input logic [31:0] x,
                    input logic [1:0] r);
    int n;
    logic ar, v;
    n = 0;
    @(posedge aclk);
    s_axi_araddr <= a;
    s_axi_arvalid <= 1'b1;
    s_axi_rready <= 1'b1;
    do begin
      @(negedge aclk);
      ar = s_axi_arready;
      v = s_axi_rvalid;
      if (v) begin
        chk(s_axi_rdata, x);
        chk(32'(s_axi_rresp), 32'(r));
      end
      @(posedge aclk);
      if (ar) s_axi_arvalid <= 1'b0;
      n++;
      hang(n);
    end while (!v);
    s_axi_rready <= 1'b0;
  endtask

  task automatic settle();
    repeat (8) @(posedge aclk);
    @(negedge aclk);
  endtask

  task automatic pins(input logic [2:0] p, input logic ph, dr, bk);
    @(posedge aclk);
    pos <= p;
    phase_sel_open <= ph;
    direction_fwd <= dr;
    brake <= bk;
    settle();
  endtask

  initial begin
    aclk = 1'b0;
    forever #5 aclk = ~aclk;
  end

  initial begin
    err_count = 0;
    cmp_count = 0;
    {aresetn, s_axi_awvalid, s_axi_wvalid, s_axi_bready} = 4'h0;
    {s_axi_arvalid, s_axi_rready, brake, pos} = 6'h00;
    {overcurrent, undervoltage, over_temp} = 3'h0;
    {output_enable, direction_fwd, phase_sel_open} = 3'h7;
    {s_axi_awaddr, s_axi_wdata, s_axi_araddr} = 96'h0;
    s_axi_wstrb = 4'hf;
    repeat (15) @(posedge aclk);
    @(negedge aclk);
    chk({up, lo, fault_n, irq}, 32'h0);
    @(posedge aclk);
    aresetn <= 1'b1;
    rd(`SCD_ADDR_CTRL, 32'hff, `SCD_RESP_OKAY);
    rd(`SCD_ADDR_IRQ_MASK, 32'h0, `SCD_RESP_OKAY);
    rd(32'h10, 32'h0, `SCD_RESP_DECERR);
    rd(`SCD_ADDR_IRQ_STATUS, 32'h0, `SCD_RESP_OKAY);
    wr(32'h10, 32'h0, `SCD_RESP_DECERR);
    wr(`SCD_ADDR_STATUS, 32'hffff_ffff, `SCD_RESP_OKAY);
    // Code 100 valid, step 0, no fault, forward, open phasing, enabled
    rd(`SCD_ADDR_STATUS, 32'h0000_168c, `SCD_RESP_OKAY);
    $display("register test done");
    for (int ph = 0; ph < 2; ph++) begin
      for (int dr = 0; dr < 2; dr++) begin
        for (int i = 0; i < 6; i++) begin
          pins(i[2:0], ph[0], dr[0], 1'b0);
          e = dr[0] ? rows[i] : {rows[i][2:0], rows[i][5:3]};
          chk({up, lo}, e);
          chk(fault_n, 1'b1);
        end
      end
    end
    $display("decode test done");
    for (int ph = 0; ph < 2; ph++) begin
      for (int p = 6; p < 8; p++) begin
        for (int b = 0; b < 2; b++) begin
          pins(p[2:0], ph[0], 1'b1, b[0]);
          chk({irq, up, lo, fault_n}, b ? 32'h0e : 32'h0);
        end
      end
    end
    pins(3'h0, 1'b1, 1'b1, 1'b1);
    chk({up, lo, fault_n}, 32'h0f);
    @(posedge aclk);
    output_enable <= 1'b0;
    settle();
    chk({up, lo, fault_n}, 32'h0e);
    pins(3'h0, 1'b1, 1'b1, 1'b0);
    chk({up, lo, fault_n}, 32'h0);
    @(posedge aclk);
    output_enable <= 1'b1;
    over_temp <= 1'b1;
    settle();
    chk({up, lo, fault_n}, 32'h0);
    @(posedge aclk);
    over_temp <= 1'b0;
    undervoltage <= 1'b1;
    settle();
    chk({up, lo, fault_n}, 32'h0);
    @(posedge aclk);
    undervoltage <= 1'b0;
    $display("protection test done");
    wr(`SCD_ADDR_CTRL, 32'h0, `SCD_RESP_OKAY);
    settle();
    chk({up, lo}, 32'h10);
    wr(`SCD_ADDR_CTRL, 32'h80, `SCD_RESP_OKAY);
    rd(`SCD_ADDR_CTRL, 32'h80, `SCD_RESP_OKAY);
    settle();
    ons = 0;
    // One full period: 128 of 255 counts at 4 clocks each
    repeat (1020) begin
      @(negedge aclk);
      ons += (lo != 3'h0);
      chk(up, 3'h2);
    end
    chk(ons, 512);
    wr(`SCD_ADDR_CTRL, 32'hff, `SCD_RESP_OKAY);
    $display("modulation test done");
    wr(`SCD_ADDR_IRQ_MASK, 32'h2, `SCD_RESP_OKAY);
    pins(3'h6, 1'b1, 1'b1, 1'b0);
    chk(irq, 1'b1);
    pins(3'h0, 1'b1, 1'b1, 1'b0);
    chk(irq, 1'b1);
    wr(`SCD_ADDR_IRQ_STATUS, 32'h2, `SCD_RESP_OKAY);
    settle();
    chk(irq, 1'b0);
    $display("interrupt test done");
    @(posedge aclk);
    overcurrent <= 1'b1;
    settle();
    chk(fault_n, 1'b0);
    @(posedge aclk);
    overcurrent <= 1'b0;
    $display("overcurrent test done");
    // Mid-run reset: registers return to reset values, no stale events
    @(posedge aclk);
    aresetn <= 1'b0;
    repeat (5) @(posedge aclk);
    @(negedge aclk);
    chk({up, lo, fault_n, irq}, 32'h0);
    @(posedge aclk);
    aresetn <= 1'b1;
    rd(`SCD_ADDR_IRQ_MASK, 32'h0, `SCD_RESP_OKAY);
    rd(`SCD_ADDR_IRQ_STATUS, 32'h0, `SCD_RESP_OKAY);
    rd(`SCD_ADDR_CTRL, 32'hff, `SCD_RESP_OKAY);
    $display("reset test done");
    final_report();
  end
endmodule

bind scd_top scd_monitor i_mon (
  .aclk(aclk),
  .aresetn(aresetn),
  .s_axi_awready(s_axi_awready),
  .s_axi_wready(s_axi_wready),
  .s_axi_bvalid(s_axi_bvalid),
  .s_axi_arvalid(s_axi_arvalid),
  .s_axi_arready(s_axi_arready),
  .s_axi_rvalid(s_axi_rvalid),
  .hall_input_a(hall_input_a),
  .hall_input_b(hall_input_b),
  .hall_input_c(hall_input_c),
  .phase_sel_open(phase_sel_open),
  .direction_fwd(direction_fwd),
  .brake(brake),
  .output_enable(output_enable),
  .overcurrent(overcurrent),
  .undervoltage(undervoltage),
  .over_temp(over_temp),
  .upper_drive_a(upper_drive_a),
  .upper_drive_b(upper_drive_b),
  .upper_drive_c(upper_drive_c),
  .lower_drive_a(lower_drive_a),
  .lower_drive_b(lower_drive_b),
  .lower_drive_c(lower_drive_c),
  .fault_n(fault_n)
);
